// >>> sdbt_timer.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - clear port write ones clear control bits
// - set port write ones set control bits
// - command field always reads zero
// - command codes: none, reserved, restart, reset
// - hard reset ignored while timer enabled
// - target field: none, reserved, both
// - irq enables: compares 6:4, underflows 1:0
// - compare match sets low compare flag
// - compare flags cleared only by software
// - high underflow sets flag, w1c
// - low underflow sets flag, w1c
// - debug halt stops timer unless run bit
// - counter write beats count and reload
// - two 8-bit counters, reset zero
// - low top register resets to ff
// - counters tick only in dual-byte mode, stopped outside it
// - high top register resets to ff
// - prescaler divides by selected ratio
module sdbt_timer #(
  parameter int NUM_CMP = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_debug_halt,
  output logic [7:0] flags_out
);

  logic [7:0] ctrla_ff;
  logic dual_byte_select_ff;
  logic [1:0] command_target_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] flags_ff;
  logic run_while_halted_ff;
  logic [7:0] low_byte_count_ff;
  logic [7:0] high_byte_count_ff;
  logic [7:0] low_byte_top_ff;
  logic [7:0] high_byte_top_ff;
  logic [7:0] low_cmp_ff [NUM_CMP];
  logic [9:0] presc_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  // access-phase strobes; a write lands at the edge that samples pready high
  logic acc;
  logic wr;
  logic in_map;
  logic [7:0] idx;
  logic [7:0] wdat;
  assign acc = psel && penable;
  // upper address bits outside the map refuse the access
  assign in_map = paddr[11:10] == 2'h0;
  assign wr = acc && pready && pwrite && pstrb[0] && in_map;
  assign idx = paddr[9:2];
  assign wdat = pwdata[7:0];

  function automatic logic wr_hit(input logic w, input logic [7:0] i, input logic [7:0] r);
    wr_hit = w && (i == r);
  endfunction

  // divider ratio per select code
  function automatic logic [9:0] presc_mask(input logic [2:0] sel);
    case (sel)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00f;
      3'h5: presc_mask = 10'h03f;
      3'h6: presc_mask = 10'h0ff;
      default: presc_mask = 10'h3ff;
    endcase
  endfunction

  // count down one step, reload from top at bottom
  function automatic logic [7:0] next_count(input logic [7:0] cnt, input logic [7:0] top);
    if (cnt == 8'h00) begin
      next_count = top;
    end else begin
      next_count = cnt - 8'h01;
    end
  endfunction

  logic enabled;
  logic halted;
  logic tick;
  logic [1:0] cmd;
  logic [1:0] tgt;
  logic set_wr;
  logic restart;
  logic hard_reset;
  // register hits of the bus write
  logic hit_clr;
  logic hit_flags;
  logic hit_low_cnt;
  logic hit_high_cnt;
  logic hit_dbg;
  assign enabled = ctrla_ff[sdbt_pkg::ENABLE_BIT];
  assign halted = cpu_debug_halt && !run_while_halted_ff;
  assign tick = enabled && !halted && dual_byte_select_ff &&
    ((presc_ff & presc_mask(ctrla_ff[3:1])) == sdbt_pkg::PRESC_ZERO);
  assign set_wr = wr_hit(wr, idx, sdbt_pkg::IDX_SET);
  assign hit_clr = wr_hit(wr, idx, sdbt_pkg::IDX_CLR);
  assign hit_flags = wr_hit(wr, idx, sdbt_pkg::IDX_IRQ_FLAGS);
  assign hit_low_cnt = wr_hit(wr, idx, sdbt_pkg::IDX_LOW_COUNT);
  assign hit_high_cnt = wr_hit(wr, idx, sdbt_pkg::IDX_HIGH_COUNT);
  assign hit_dbg = wr_hit(wr, idx, sdbt_pkg::IDX_DBG);
  assign cmd = wdat[sdbt_pkg::CMD_LSB +: 2];
  // command takes the target as it stands after this write
  assign tgt = command_target_ff | wdat[sdbt_pkg::TGT_LSB +: 2];
  // reserved command and target codes act as no command
  assign restart = set_wr && cmd == sdbt_pkg::CMD_RESTART &&
    tgt == sdbt_pkg::TGT_BOTH;
  assign hard_reset = set_wr && cmd == sdbt_pkg::CMD_HARD_RESET &&
    tgt == sdbt_pkg::TGT_BOTH && !enabled;

  // prescaler counter, frozen while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= sdbt_pkg::PRESC_ZERO;
    end else if (hard_reset || restart || !enabled) begin
      presc_ff <= sdbt_pkg::PRESC_ZERO;
    end else if (!halted) begin
      presc_ff <= presc_ff + 10'h001;
    end
  end

  // control a register: enable, prescale select, bit 7 kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrla_ff <= sdbt_pkg::RST_ZERO;
    end else if (wr_hit(wr, idx, sdbt_pkg::IDX_CTRLA)) begin
      ctrla_ff <= wdat & 8'h8f;
    end
  end

  // mode register: dual-byte select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_byte_select_ff <= 1'b0;
    end else if (wr_hit(wr, idx, sdbt_pkg::IDX_MODE)) begin
      dual_byte_select_ff <= wdat[0];
    end
  end

  // command target via set and clear ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_target_ff <= 2'h0;
    end else if (hard_reset) begin
      command_target_ff <= 2'h0;
    end else if (hit_clr) begin
      command_target_ff <= command_target_ff & ~wdat[1:0];
    end else if (set_wr) begin
      command_target_ff <= command_target_ff | wdat[1:0];
    end
  end

  // interrupt enables, cleared by hard reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= sdbt_pkg::RST_ZERO;
    end else if (hard_reset) begin
      irq_en_ff <= sdbt_pkg::RST_ZERO;
    end else if (wr_hit(wr, idx, sdbt_pkg::IDX_IRQ_EN)) begin
      irq_en_ff <= wdat & sdbt_pkg::IRQ_MASK;
    end
  end

  // debug control: run while the cpu is halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_while_halted_ff <= 1'b0;
    end else if (hit_dbg) begin
      run_while_halted_ff <= wdat[0];
    end
  end

  // period registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_byte_top_ff <= sdbt_pkg::RST_TOP;
      high_byte_top_ff <= sdbt_pkg::RST_TOP;
    end else if (hard_reset) begin
      low_byte_top_ff <= sdbt_pkg::RST_TOP;
      high_byte_top_ff <= sdbt_pkg::RST_TOP;
    end else begin
      if (wr_hit(wr, idx, sdbt_pkg::IDX_LTOP)) begin
        low_byte_top_ff <= wdat;
      end
      if (wr_hit(wr, idx, sdbt_pkg::IDX_HTOP)) begin
        high_byte_top_ff <= wdat;
      end
    end
  end

  // low compare registers, two indices (two words) apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        low_cmp_ff[i] <= sdbt_pkg::RST_ZERO;
      end
    end else if (hard_reset) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        low_cmp_ff[i] <= sdbt_pkg::RST_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (wr_hit(wr, idx, sdbt_pkg::IDX_LOW_CMP0 + 8'(2 * i))) begin
          low_cmp_ff[i] <= wdat;
        end
      end
    end
  end

  // low counter: bus write wins, then reset, restart, count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_byte_count_ff <= sdbt_pkg::RST_ZERO;
    end else if (hit_low_cnt) begin
      low_byte_count_ff <= wdat;
    end else if (hard_reset) begin
      low_byte_count_ff <= sdbt_pkg::RST_ZERO;
    end else if (restart) begin
      low_byte_count_ff <= low_byte_top_ff;
    end else if (tick) begin
      low_byte_count_ff <= next_count(low_byte_count_ff, low_byte_top_ff);
    end
  end

  // high counter: same priorities
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_byte_count_ff <= sdbt_pkg::RST_ZERO;
    end else if (hit_high_cnt) begin
      high_byte_count_ff <= wdat;
    end else if (hard_reset) begin
      high_byte_count_ff <= sdbt_pkg::RST_ZERO;
    end else if (restart) begin
      high_byte_count_ff <= high_byte_top_ff;
    end else if (tick) begin
      high_byte_count_ff <= next_count(high_byte_count_ff, high_byte_top_ff);
    end
  end

  // event detection: counter arrives at bottom or matches compare
  logic [7:0] ev;
  logic [7:0] low_byte_count_q;
  logic [7:0] high_byte_count_q;
  // low counter history; hard reset leaves no false event behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_byte_count_q <= sdbt_pkg::RST_ZERO;
    end else if (hard_reset && !hit_low_cnt) begin
      low_byte_count_q <= sdbt_pkg::RST_ZERO;
    end else begin
      low_byte_count_q <= low_byte_count_ff;
    end
  end

  // high counter history, same treatment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_byte_count_q <= sdbt_pkg::RST_ZERO;
    end else if (hard_reset && !hit_high_cnt) begin
      high_byte_count_q <= sdbt_pkg::RST_ZERO;
    end else begin
      high_byte_count_q <= high_byte_count_ff;
    end
  end

  // a counter counts as moved when it differs from last cycle and the timer is not halted
  logic lchg;
  logic hchg;
  assign lchg = (low_byte_count_q != low_byte_count_ff) && !halted;
  assign hchg = (high_byte_count_q != high_byte_count_ff) && !halted;
  always_comb begin
    ev = 8'h00;
    ev[sdbt_pkg::FLAG_LOW_UNDER] = lchg && low_byte_count_ff == 8'h00;
    ev[sdbt_pkg::FLAG_HIGH_UNDER] = hchg && high_byte_count_ff == 8'h00;
    for (int i = 0; i < NUM_CMP; i++) begin
      ev[sdbt_pkg::FLAG_LCMP_LSB + i] = lchg && low_byte_count_ff == low_cmp_ff[i];
    end
  end

  // sticky flags, write one clears, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= sdbt_pkg::RST_ZERO;
    end else if (hard_reset) begin
      flags_ff <= sdbt_pkg::RST_ZERO;
    end else if (hit_flags) begin
      flags_ff <= ((flags_ff & ~wdat) | ev) & sdbt_pkg::IRQ_MASK;
    end else begin
      flags_ff <= (flags_ff | ev) & sdbt_pkg::IRQ_MASK;
    end
  end

  // read mux
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (idx)
      sdbt_pkg::IDX_CTRLA: nxt_prdata[7:0] = ctrla_ff;
      sdbt_pkg::IDX_MODE: nxt_prdata[0] = dual_byte_select_ff;
      sdbt_pkg::IDX_CLR, sdbt_pkg::IDX_SET:
        nxt_prdata[1:0] = command_target_ff;
      sdbt_pkg::IDX_IRQ_EN: nxt_prdata[7:0] = irq_en_ff;
      sdbt_pkg::IDX_IRQ_FLAGS: nxt_prdata[7:0] = flags_ff;
      sdbt_pkg::IDX_DBG: nxt_prdata[0] = run_while_halted_ff;
      sdbt_pkg::IDX_LOW_COUNT: nxt_prdata[7:0] = low_byte_count_ff;
      sdbt_pkg::IDX_HIGH_COUNT: nxt_prdata[7:0] = high_byte_count_ff;
      sdbt_pkg::IDX_LTOP: nxt_prdata[7:0] = low_byte_top_ff;
      sdbt_pkg::IDX_HTOP: nxt_prdata[7:0] = high_byte_top_ff;
      8'h28: nxt_prdata[7:0] = low_cmp_ff[0];
      8'h2a: nxt_prdata[7:0] = low_cmp_ff[1];
      8'h2c: nxt_prdata[7:0] = low_cmp_ff[2];
      default: nxt_pslverr = 1'b1;
    endcase
    // refused access reads back zero
    if (!in_map) begin
      nxt_pslverr = 1'b1;
      nxt_prdata = 32'h0000_0000;
    end
  end

  // registered answer: pready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (acc && !pready) begin
      prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pready <= 1'b1;
      pslverr <= nxt_pslverr;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // flags gated by enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_out <= sdbt_pkg::RST_ZERO;
    end else begin
      flags_out <= flags_ff & irq_en_ff;
    end
  end

endmodule

// >>> sdbt_pkg.sv
package sdbt_pkg;
  // register offsets; several printed offsets are not multiples of four,
  // so each is an index and the byte address is four times it
  localparam logic [7:0] IDX_CTRLA = 8'h00;
  localparam logic [7:0] IDX_MODE = 8'h03;
  localparam logic [7:0] IDX_CLR = 8'h04;
  localparam logic [7:0] IDX_SET = 8'h05;
  localparam logic [7:0] IDX_IRQ_EN = 8'h0a;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0b;
  localparam logic [7:0] IDX_DBG = 8'h0e;
  localparam logic [7:0] IDX_LOW_COUNT = 8'h20;
  localparam logic [7:0] IDX_HIGH_COUNT = 8'h21;
  localparam logic [7:0] IDX_LTOP = 8'h26;
  localparam logic [7:0] IDX_HTOP = 8'h27;
  localparam logic [7:0] IDX_LOW_CMP0 = 8'h28;
  // field positions
  localparam int CMD_LSB = 2;
  localparam int TGT_LSB = 0;
  localparam int ENABLE_BIT = 0;
  localparam int PRESC_LSB = 1;
  localparam int FLAG_LCMP_LSB = 4;
  localparam int FLAG_HIGH_UNDER = 1;
  localparam int FLAG_LOW_UNDER = 0;
  // command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET = 2'h3;
  localparam logic [1:0] TGT_BOTH = 2'h3;
  // reset values and masks
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TOP = 8'hff;
  localparam logic [7:0] CTRLE_MASK = 8'h03;
  localparam logic [7:0] IRQ_MASK = 8'h73;
  localparam logic [9:0] PRESC_ZERO = 10'h000;
endpackage

// >>> sdbt_timer_props.sv
`timescale 1ns/1ps
module sdbt_timer_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_debug_halt,
  input wire logic [7:0] flags_out
);
  // write taken at the edge that samples pready high
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase still waiting for its answer
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_rd_cmd;
    s_acc ##0 (!pwrite && paddr[9:3] == 7'h02);
  endsequence
  sequence s_rd_bad;
    s_acc ##0 (!pwrite && paddr[11:10] != 2'h0);
  endsequence
  AST_READY_LAT: assert property (s_acc |=> pready)
    else $error("access not answered");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_ADDR: assert property (s_rd_bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_CMD_ZERO: assert property (s_rd_cmd |=> prdata[3:2] == 2'h0)
    else $error("command field read nonzero");
  AST_BYTE_WIDE: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above the byte nonzero");
  AST_FLAG_MAP: assert property (flags_out[7] == 1'b0 && flags_out[3:2] == 2'h0)
    else $error("flag output on an unused bit");
  AST_FLAG_HOLD: assert property (
    |($past(flags_out) & ~flags_out) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("flag dropped without a write");
endmodule
bind sdbt_timer sdbt_timer_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_debug_halt(cpu_debug_halt),
  .flags_out(flags_out));

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cpu_debug_halt = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] flags_out;
  int fails = 0, samples_checked = 0;
  typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} sdbt_row_t;
  // reset values, then write and read back
  sdbt_row_t rows [16] = '{'{1'b0, 8'h26, 8'h00, 8'hff}, '{1'b0, 8'h27, 8'h00, 8'hff},
    '{1'b0, 8'h20, 8'h00, 8'h00}, '{1'b0, 8'h21, 8'h00, 8'h00}, '{1'b0, 8'h0a, 8'h00, 8'h00},
    '{1'b0, 8'h0b, 8'h00, 8'h00}, '{1'b0, 8'h0e, 8'h00, 8'h00}, '{1'b0, 8'h05, 8'h00, 8'h00},
    '{1'b1, 8'h0a, 8'hff, 8'h73}, '{1'b1, 8'h0e, 8'h01, 8'h01}, '{1'b1, 8'h20, 8'h5a, 8'h5a},
    '{1'b1, 8'h21, 8'ha5, 8'ha5}, '{1'b1, 8'h26, 8'h10, 8'h10}, '{1'b1, 8'h05, 8'h03, 8'h03},
    '{1'b1, 8'h05, 8'h04, 8'h03}, '{1'b1, 8'h04, 8'h01, 8'h02}};
  sdbt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_debug_halt(cpu_debug_halt), .flags_out(flags_out));
  // clock
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] s = 4'h1, input logic [1:0] hi = 2'h0);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {hi, idx, 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].wd);
      rc(rows[i].idx, rows[i].exp);
    end
    $display("register table done");
    // count down to bottom with compares
    apb(1'b1, 8'h26, 8'h03);
    apb(1'b1, 8'h20, 8'h03);
    apb(1'b1, 8'h21, 8'h02);
    apb(1'b1, 8'h28, 8'h02);
    apb(1'b1, 8'h03, 8'h01);
    apb(1'b1, 8'h00, 8'h01);
    for (int n = 0; n < 40 && flags_out !== 8'h73; n++) @(posedge pclk);
    apb(1'b1, 8'h00, 8'h00);
    check(flags_out, 8'h73);
    rc(8'h0b, 8'h73);
    apb(1'b0, 8'h20, 8'h00);
    check(rd[7:0] <= 8'h03, 1'b1);
    apb(1'b1, 8'h0b, 8'h10);
    rc(8'h0b, 8'h63);
    apb(1'b1, 8'h20, 8'h20);
    apb(1'b1, 8'h00, 8'h0f);
    repeat (100) @(posedge pclk);
    apb(1'b0, 8'h20, 8'h00);
    check(rd[7:0] >= 8'h1f, 1'b1);
    $display("count test done");
    // debug halt
    cpu_debug_halt <= 1'b1;
    apb(1'b1, 8'h0e, 8'h00);
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b1, 8'h20, 8'h40);
    repeat (20) @(posedge pclk);
    rc(8'h20, 8'h40);
    apb(1'b1, 8'h0e, 8'h01);
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h20, 8'h00);
    check(rd[7:0] !== 8'h40, 1'b1);
    cpu_debug_halt <= 1'b0;
    apb(1'b1, 8'h00, 8'h00);
    $display("debug test done");
    // commands
    apb(1'b1, 8'h26, 8'h33);
    apb(1'b1, 8'h05, 8'h0b);
    rc(8'h20, 8'h33);
    rc(8'h21, 8'hff);
    apb(1'b1, 8'h04, 8'h03);
    apb(1'b1, 8'h05, 8'h0c);
    rc(8'h26, 8'h33);
    apb(1'b1, 8'h05, 8'h0d);
    rc(8'h26, 8'h33);
    apb(1'b1, 8'h00, 8'h01);
    apb(1'b1, 8'h05, 8'h0f);
    rc(8'h26, 8'h33);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b1, 8'h05, 8'h0f);
    rc(8'h26, 8'hff);
    rc(8'h0a, 8'h00);
    $display("command test done");
    // refused accesses and a second reset
    apb(1'b1, 8'h26, 8'h55, 4'h0);
    rc(8'h26, 8'hff);
    apb(1'b0, 8'h00, 8'h00, 4'h1, 2'h3);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, 8'h26, 8'h44);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(flags_out, 8'h00);
    presetn <= 1'b1;
    rc(8'h26, 8'hff);
    $display("error and reset test done");
    print_verdict();
  end
endmodule
